// File: apl_pkg.sv
// Shared constants and types of the alert pin logic
package apl_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_SEL_ONE = 8'h00;
  localparam logic [7:0] REG_SEL_TWO = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CLEAR = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  localparam logic [7:0] REG_ADDR = 8'h18;
  // Control field positions
  localparam int CTRL_INV_ONE = 0;
  localparam int CTRL_INV_TWO = 1;
  localparam int CTRL_CMP_ONE = 2;
  localparam int CTRL_CMP_TWO = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Pin state field positions
  localparam int PINS_ONE = 0;
  localparam int PINS_TWO = 1;
  localparam int PINS_BUSY = 2;
  // SMBus alert response address and default own address
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    ARA_IDLE, ARA_ADDRB, ARA_ACK, ARA_SEND, ARA_NACK
  } apl_ara_t;
endpackage

// File: apl_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module apl_sync #(
  parameter int W = 2
) (
  input wire logic ref_clk, // Device clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic [W-1:0] din, // Asynchronous inputs
  output logic [W-1:0] dout // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } apl_sync_t;
  apl_sync_t q;
  apl_sync_t d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  // Idle bus level is high
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

// File: apl_pin.sv
// One alert pin: latched alert, comparator mode and polarity
`timescale 1ns/10ps
module apl_pin #(
  parameter int NSRC = 16
) (
  input wire logic ref_clk, // Device clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic [NSRC-1:0] statRise, // Status bits going 0 to 1
  input wire logic [NSRC-1:0] sel, // Sources enabled on this pin
  input wire logic [NSRC-1:0] cmpLive, // Live limit comparisons
  input wire logic cmpMode, // Digital comparator mode
  input wire logic invert, // Active level high
  input wire logic relAll, // Release pulse, both pins
  output logic flag, // Latched alert
  output logic pinActive, // Pin in active state
  output logic pinOe // Pull pin low
);
  typedef struct packed {
    logic latch;
  } apl_pin_t;
  apl_pin_t q;
  apl_pin_t d;
  logic newAlert;

  always_comb begin
    newAlert = |(statRise & sel);
    d = q;
    if (newAlert) begin
      d.latch = 1'b1;
    end else if (relAll) begin
      d.latch = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flag = q.latch;
  // Comparator mode is unlatched
  assign pinActive = cmpMode ? |(cmpLive & sel) : q.latch;
  // Open drain: an inverted pin is released when active
  assign pinOe = pinActive ^ invert;

  a_rise_sets_alert: assert property (@(posedge ref_clk)
    disable iff (sys_rst) |(statRise & sel) |=> flag)
    else $error("enabled status rise did not latch alert");
  a_no_rise_quiet: assert property (@(posedge ref_clk)
    disable iff (sys_rst) (!flag && !(|(statRise & sel))) |=> !flag)
    else $error("alert latched without enabled rise");
  a_release_clears: assert property (@(posedge ref_clk)
    disable iff (sys_rst) (relAll && !(|(statRise & sel))) |=> !flag)
    else $error("release did not drop alert");
  a_cmp_follows: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    cmpMode |-> pinOe == ((|(cmpLive & sel)) != invert))
    else $error("comparator pin not following live compare");
  a_pin_polarity: assert property (@(posedge ref_clk)
    disable iff (sys_rst) !cmpMode |-> pinOe == (flag != invert))
    else $error("pin drive does not match polarity");
endmodule

// File: apl_alert.sv
// Alert pin logic with status latching, APB registers and SMBus ARA
//
// Overview of operation
// - After reset both alert pins float and no source is enabled.
// - Any fault or warning may be enabled per pin to assert it.
// - Pins are active low by default, with per-pin polarity inversion.
// - Only a 0 to 1 status change of an enabled source raises alert.
// - Pins assert independently but any release drops both together.
// - Clear-faults clears status bits and releases the alert pins.
// - A persistent fault keeps its bit set but raises no alert.
// - A still-violating monitor sample after a clear re-raises the alert.
// - Host reads address 0x0C; device answers when its alert is active.
// - Answer byte carries own 7-bit address in its upper bits.
// - Lowest address wins arbitration; only the winner drops its alert.
// - The winner releases its alert pin at the not-acknowledge bit.
// - After service, pins stay inactive and status stays unchanged.
// - Comparator mode: pin follows live limit comparison, unlatched.
// - Comparator mode uses the same per-pin source selection.
// - Enabled output undervoltage sample below limit pulls the pin.
// - Status bits latch; clear only resets bits no longer active.
`timescale 1ns/10ps
module apl_alert #(
  parameter int NSRC = 16,
  parameter logic [6:0] OWN_ADDR = apl_pkg::OWN_ADDR_RESET
) (
  input wire logic ref_clk, // 200 MHz device clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [NSRC-1:0] srcLive, // Live fault/warning conditions
  input wire logic [NSRC-1:0] cmpLive, // Live measure vs warning limit
  input wire logic clearCmd, // Clear-faults command pulse
  input wire logic sclIn, // SMBus clock pin
  input wire logic sdaIn, // SMBus data pin
  output logic sdaOut, // SMBus data out, always 0
  output logic sdaOe, // SMBus data pull low
  output logic alertOutOne, // Alert pin one out, always 0
  output logic alertOutOneOe, // Alert pin one pull low
  output logic alertOutTwo, // Alert pin two out, always 0
  output logic alertOutTwoOe // Alert pin two pull low
);
  import apl_pkg::*;

  typedef struct packed {
    apl_ara_t st;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic ackPh;
    logic sdaDrv;
    logic sclPrev;
    logic sdaPrev;
    logic [NSRC-1:0] stat;
    logic [NSRC-1:0] selOne;
    logic [NSRC-1:0] selTwo;
    logic [3:0] ctrl;
    logic [6:0] ownAddr;
    logic [31:0] rdata;
  } apl_state_t;

  apl_state_t q;
  apl_state_t d;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic apbWr;
  logic apbSetup;
  logic addrOk;
  logic clearReq;
  logic araWin;
  logic relAll;
  logic [NSRC-1:0] statRise;
  logic flagOne;
  logic flagTwo;
  logic actOne;
  logic actTwo;
  logic [7:0] txByte;

  apl_sync #(
    .W(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .din({sclIn, sdaIn}),
    .dout({sclS, sdaS})
  );

  assign sclRise = sclS && !q.sclPrev;
  assign sclFall = !sclS && q.sclPrev;
  assign startCond = sclS && q.sclPrev && q.sdaPrev && !sdaS;
  assign stopCond = sclS && q.sclPrev && !q.sdaPrev && sdaS;

  // Zero-wait APB slave
  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pwrite;
  always_comb begin
    case (paddr)
      REG_SEL_ONE, REG_SEL_TWO, REG_CTRL, REG_STATUS,
      REG_CLEAR, REG_PINS, REG_ADDR: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;

  assign clearReq = clearCmd || (apbWr && paddr == REG_CLEAR);
  assign relAll = clearReq || araWin;
  // Bit 0 is don't care; sent as 1 so it never wins a lane
  assign txByte = {q.ownAddr, 1'b1};

  always_comb begin
    d = q;
    araWin = 1'b0;
    d.sclPrev = sclS;
    d.sdaPrev = sdaS;
    // Live conditions win over a clear in the same cycle
    if (clearReq) begin
      d.stat = srcLive;
    end else begin
      d.stat = q.stat | srcLive;
    end
    // Warnings arrive per sample, so a cleared bit rises again
    statRise = d.stat & ~q.stat;

    if (apbSetup) begin
      case (paddr)
        REG_SEL_ONE: d.rdata = 32'(q.selOne);
        REG_SEL_TWO: d.rdata = 32'(q.selTwo);
        REG_CTRL: d.rdata = {28'h000_0000, q.ctrl};
        REG_STATUS: d.rdata = 32'(q.stat);
        REG_PINS: d.rdata = {29'h0000_0000, q.st != ARA_IDLE,
          actTwo, actOne};
        REG_ADDR: d.rdata = {25'h000_0000, q.ownAddr};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (apbWr) begin
      case (paddr)
        REG_SEL_ONE: d.selOne = pwdata[NSRC-1:0];
        REG_SEL_TWO: d.selTwo = pwdata[NSRC-1:0];
        REG_CTRL: d.ctrl = pwdata[3:0];
        REG_ADDR: d.ownAddr = pwdata[6:0];
        default: d.ctrl = q.ctrl;
      endcase
    end

    case (q.st)
      ARA_IDLE: begin
        d.sdaDrv = 1'b0;
      end
      ARA_ADDRB: begin
        if (sclRise) begin
          d.shift = {q.shift[6:0], sdaS};
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == LAST_BIT) begin
            // Answer only a read of 0x0C with an alert pending
            if ({q.shift[6:0], sdaS} == {ARA_ADDR, 1'b1} &&
                (flagOne || flagTwo)) begin
              d.st = ARA_ACK;
              d.ackPh = 1'b0;
            end else begin
              d.st = ARA_IDLE;
            end
          end
        end
      end
      ARA_ACK: begin
        if (sclFall) begin
          if (!q.ackPh) begin
            d.ackPh = 1'b1;
            d.sdaDrv = 1'b1;
          end else begin
            d.st = ARA_SEND;
            d.cnt = 3'h0;
            d.sdaDrv = !txByte[7];
          end
        end
      end
      ARA_SEND: begin
        if (sclRise) begin
          if (!q.sdaDrv && !sdaS) begin
            // Lower address owns the line; keep our alert up
            d.sdaDrv = 1'b0;
            d.st = ARA_IDLE;
          end else begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == LAST_BIT) begin
              d.st = ARA_NACK;
            end
          end
        end else if (sclFall) begin
          d.sdaDrv = !txByte[3'(LAST_BIT - q.cnt)];
        end
      end
      ARA_NACK: begin
        if (sclFall) begin
          // Whole address sent: drop alert at the NACK bit
          d.sdaDrv = 1'b0;
          araWin = 1'b1;
          d.st = ARA_IDLE;
        end
      end
      default: begin
        d.st = ARA_IDLE;
      end
    endcase

    if (startCond) begin
      d.st = ARA_ADDRB;
      d.cnt = 3'h0;
      d.sdaDrv = 1'b0;
    end else if (stopCond) begin
      d.st = ARA_IDLE;
      d.sdaDrv = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q.st <= ARA_IDLE;
      q.shift <= 8'h00;
      q.cnt <= 3'h0;
      q.ackPh <= 1'b0;
      q.sdaDrv <= 1'b0;
      q.sclPrev <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.stat <= '0;
      q.selOne <= '0;
      q.selTwo <= '0;
      q.ctrl <= CTRL_RESET;
      q.ownAddr <= OWN_ADDR;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  apl_pin #(
    .NSRC(NSRC)
  ) u_pin_one (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .statRise(statRise),
    .sel(q.selOne),
    .cmpLive(cmpLive),
    .cmpMode(q.ctrl[CTRL_CMP_ONE]),
    .invert(q.ctrl[CTRL_INV_ONE]),
    .relAll(relAll),
    .flag(flagOne),
    .pinActive(actOne),
    .pinOe(alertOutOneOe)
  );

  apl_pin #(
    .NSRC(NSRC)
  ) u_pin_two (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .statRise(statRise),
    .sel(q.selTwo),
    .cmpLive(cmpLive),
    .cmpMode(q.ctrl[CTRL_CMP_TWO]),
    .invert(q.ctrl[CTRL_INV_TWO]),
    .relAll(relAll),
    .flag(flagTwo),
    .pinActive(actTwo),
    .pinOe(alertOutTwoOe)
  );

  assign alertOutOne = 1'b0;
  assign alertOutTwo = 1'b0;
  assign sdaOut = 1'b0;
  assign sdaOe = q.sdaDrv;
  assign prdata = q.rdata;

  a_reset_pins_float: assert property (@(posedge ref_clk)
    sys_rst |=> !alertOutOneOe && !alertOutTwoOe)
    else $error("alert pin driven after reset");
  a_clear_keeps_live: assert property (@(posedge ref_clk)
    disable iff (sys_rst) clearReq |=> q.stat == $past(srcLive))
    else $error("clear did not leave exactly live bits");
  a_status_latched: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    !clearReq |=> (q.stat & $past(q.stat)) == $past(q.stat))
    else $error("latched status bit lost without clear");
  a_lost_stops_drive: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (q.st == ARA_SEND && sclRise && !q.sdaDrv && !sdaS &&
     !startCond) |=> !sdaOe && q.st == ARA_IDLE && !araWin)
    else $error("device kept driving after losing a bit");
  a_win_drops_both: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (araWin && !(|statRise)) |=> !flagOne && !flagTwo)
    else $error("won response did not drop alerts");
  a_clear_drops_both: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (clearReq && !(|statRise)) |=> !flagOne && !flagTwo)
    else $error("clear did not release both alert pins");

  // Response exchange: SDA is only pulled while answering
  a_idle_no_drive: assert property (@(posedge ref_clk)
    disable iff (sys_rst) q.st == ARA_IDLE |-> !sdaOe)
    else $error("SDA driven outside a response exchange");
  a_ack_needs_alert: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (q.st == ARA_ADDRB && sclRise && q.cnt == LAST_BIT && !startCond &&
     !flagOne && !flagTwo) |=> q.st == ARA_IDLE)
    else $error("response acknowledged without an alert");
  a_ack_drives_low: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (q.st == ARA_ACK && sclFall && !q.ackPh && !startCond && !stopCond)
    |=> sdaOe)
    else $error("response address not acknowledged");
  // Address may be rewritten mid exchange, so compare the old MSB
  a_first_bit_msb: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (q.st == ARA_ACK && sclFall && q.ackPh && !startCond && !stopCond)
    |=> sdaOe == !$past(q.ownAddr[6]))
    else $error("answer byte does not open with address MSB");
  a_nack_releases: assert property (@(posedge ref_clk)
    disable iff (sys_rst) (q.st == ARA_NACK && sclFall) |=> !sdaOe)
    else $error("SDA still driven in the NACK bit");
  a_lost_keeps_alert: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    (q.st == ARA_SEND && sclRise && !q.sdaDrv && !sdaS && !clearReq &&
     (flagOne || flagTwo)) |=> (flagOne || flagTwo))
    else $error("alert dropped after lost arbitration");
  // A host may stop at any bit; nothing may keep SDA held
  a_stop_aborts: assert property (@(posedge ref_clk)
    disable iff (sys_rst) stopCond |=> q.st == ARA_IDLE && !sdaOe)
    else $error("stop condition did not end the exchange");
endmodule

// File: apl_smb_host.sv
// SMBus host model issuing alert response reads
`timescale 1ns/10ps
module apl_smb_host (
  output logic scl, // Host SMBus clock
  output logic sdaLow, // Host pulls SDA low
  input wire logic sda // Resolved SDA line
);
  import apl_pkg::*;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // One bit: SCL low 24 ns, high 24 ns, sampled mid high
  task automatic clkBit(input logic low, output logic smp);
    #12 sdaLow = low;
    #12 scl = 1'b1;
    #12 smp = sda;
    #12 scl = 1'b0;
  endtask
  // Rival stands for a second device on the wired-AND data line
  task automatic araRead(input logic [6:0] rival, input logic rivalOn,
      output logic [7:0] data, output logic ack);
    logic [7:0] addrByte;
    logic [7:0] rivalByte;
    logic smp;
    addrByte = {ARA_ADDR, 1'b1};
    rivalByte = {rival, 1'b1};
    #24 sdaLow = 1'b1;
    #24 scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clkBit(!addrByte[i], smp);
    end
    clkBit(1'b0, smp);
    ack = !smp;
    for (int i = 7; i >= 0; i--) begin
      clkBit(rivalOn && !rivalByte[i], data[i]);
    end
    clkBit(1'b0, smp);
    #12 sdaLow = 1'b1;
    #12 scl = 1'b1;
    #12 sdaLow = 1'b0;
    #24;
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the alert pin logic
`timescale 1ns/10ps
module tb_top;
  import apl_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] srcLive = 16'h0000;
  logic [15:0] cmpLive = 16'h0000;
  logic clearCmd = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sdaOe, oeOne, oeTwo, scl, sdaLow, ack, err;
  logic [7:0] ara;
  logic outOne, outTwo, sdaOutW;
  int errorCnt = 0;
  int samplesChecked = 0;
  wire logic sda = !(sdaLow | sdaOe);
  initial forever #2.5 ref_clk = ~ref_clk;
  apl_alert DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srcLive(srcLive), .cmpLive(cmpLive), .clearCmd(clearCmd),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOutW), .sdaOe(sdaOe),
    .alertOutOne(outOne), .alertOutOneOe(oeOne), .alertOutTwo(outTwo),
    .alertOutTwoOe(oeTwo));
  apl_smb_host host (.scl(scl), .sdaLow(sdaLow), .sda(sda));
  task automatic endOfTest;
    $display("errors=%0d checks=%0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chkBit(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errorCnt++;
      endOfTest();
    end
  endtask
  task automatic waitC(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulseClear;
    @(posedge ref_clk);
    clearCmd <= 1'b1;
    @(posedge ref_clk);
    clearCmd <= 1'b0;
  endtask
  // Monitor warnings arrive as one-cycle pulses per sample
  task automatic pulseSrc(input int b);
    @(posedge ref_clk);
    srcLive[b] <= 1'b1;
    @(posedge ref_clk);
    srcLive[b] <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chkBit(oeOne, 1'b0);
    chkBit(oeTwo, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0);
    chkWord(rd, 32'h0);
    apb(1'b0, REG_SEL_ONE, 32'h0);
    chkWord(rd, 32'h0);
    apb(1'b0, REG_ADDR, 32'h0);
    chkWord(rd, 32'h0010);
    apb(1'b0, 8'h1C, 32'h0);
    chkBit(err, 1'b1);
    apb(1'b1, REG_SEL_ONE, 32'h0008);
    apb(1'b1, REG_SEL_TWO, 32'h0020);
    srcLive[3] <= 1'b1;
    waitC(4);
    chkBit(oeOne, 1'b1);
    chkBit(oeTwo, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chkWord(rd, 32'h0008);
    pulseClear();
    waitC(3);
    chkBit(oeOne, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chkWord(rd, 32'h0008);
    waitC(8);
    chkBit(oeOne, 1'b0);
    pulseSrc(5);
    waitC(3);
    chkBit(oeTwo, 1'b1);
    chkBit(oeOne, 1'b0);
    apb(1'b1, REG_CTRL, 32'h2);
    #1;
    chkBit(oeTwo, 1'b0);
    apb(1'b0, REG_PINS, 32'h0);
    chkWord(rd, 32'h0002);
    apb(1'b1, REG_CTRL, 32'h0);
    host.araRead(7'h00, 1'b0, ara, ack);
    chkBit(ack, 1'b1);
    chkWord({25'h0, ara[7:1]}, 32'h0010);
    waitC(3);
    chkBit(oeTwo, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chkWord(rd, 32'h0028);
    host.araRead(7'h00, 1'b0, ara, ack);
    chkBit(ack, 1'b0);
    @(posedge ref_clk);
    srcLive[3] <= 1'b0;
    pulseClear();
    apb(1'b0, REG_STATUS, 32'h0);
    chkWord(rd, 32'h0);
    pulseSrc(5);
    waitC(3);
    chkBit(oeTwo, 1'b1);
    host.araRead(7'h08, 1'b1, ara, ack);
    chkWord({25'h0, ara[7:1]}, 32'h0008);
    waitC(3);
    chkBit(oeTwo, 1'b1);
    for (int i = 0; i < 4 && (oeOne | oeTwo); i++) begin
      host.araRead(7'h00, 1'b0, ara, ack);
    end
    chkWord({25'h0, ara[7:1]}, 32'h0010);
    chkBit(oeTwo, 1'b0);
    apb(1'b1, REG_SEL_ONE, 32'h0002);
    apb(1'b1, REG_CTRL, 32'h0004);
    cmpLive[0] <= 1'b1;
    waitC(2);
    chkBit(oeOne, 1'b0);
    @(posedge ref_clk);
    cmpLive[1] <= 1'b1;
    waitC(2);
    chkBit(oeOne, 1'b1);
    @(posedge ref_clk);
    cmpLive[1] <= 1'b0;
    waitC(2);
    chkBit(oeOne, 1'b0);
    apb(1'b1, REG_SEL_TWO, 32'h0002);
    apb(1'b1, REG_CTRL, 32'h0009);
    #1;
    chkBit(oeOne, 1'b1);
    chkBit(oeTwo, 1'b0);
    @(posedge ref_clk);
    cmpLive[1] <= 1'b1;
    waitC(2);
    chkBit(oeTwo, 1'b1);
    apb(1'b1, REG_CLEAR, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chkWord(rd, 32'h0);
    apb(1'b1, REG_ADDR, 32'h0005);
    apb(1'b0, REG_ADDR, 32'h0);
    chkWord(rd, 32'h0005);
    chkWord({29'h0, sdaOutW, outOne, outTwo}, 32'h0);
    // Second reset in mid-run must restore the power-up state
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chkBit(oeOne, 1'b0);
    chkBit(oeTwo, 1'b0);
    apb(1'b0, REG_SEL_TWO, 32'h0);
    chkWord(rd, 32'h0);
    apb(1'b0, REG_ADDR, 32'h0);
    chkWord(rd, 32'h0010);
    endOfTest();
  end
endmodule
